// File: rtl/timer_channel_pkg.sv
// Constants for the timer channel block: register map, field positions, modes.
// Assumes an 8-bit register view carried in the low byte of 32-bit APB data.
package timer_channel_pkg;

  // Register byte addresses
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNTER_HIGH  = 8'h04;
  localparam logic [7:0] OFF_COUNTER_LOW   = 8'h08;
  localparam logic [7:0] OFF_MODULUS_HIGH  = 8'h0C;
  localparam logic [7:0] OFF_MODULUS_LOW   = 8'h10;
  localparam logic [7:0] OFF_CH_BASE       = 8'h14;
  localparam logic [7:0] OFF_CH_STRIDE     = 8'h0C;
  localparam logic [7:0] OFF_CH_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_CH_VALUE_HIGH = 8'h04;
  localparam logic [7:0] OFF_CH_VALUE_LOW  = 8'h08;

  // Timer control fields
  localparam int TC_FLAG = 7;
  localparam int TC_IE   = 6;
  localparam int TC_CAS  = 5;
  localparam int TC_EN   = 0;

  // Channel control fields
  localparam int CC_FLAG = 7;
  localparam int CC_IE   = 6;
  localparam int CC_MSB  = 5;
  localparam int CC_MSA  = 4;
  localparam int CC_ELSB = 3;
  localparam int CC_ELSA = 2;

  // Counter values
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam int          SIGN_BIT   = 15;

  // Channel operating modes
  typedef enum logic [3:0] {
    MODE_CAPTURE = 4'b0001,
    MODE_COMPARE = 4'b0010,
    MODE_EDGE    = 4'b0100,
    MODE_CENTER  = 4'b1000
  } ch_mode_e;

endpackage

// File: rtl/timer_channel_capture_compare_pwm.sv
// Channel logic of a 16-bit timer: capture, compare, edge and center PWM.
// Assumes an APB master on clock; channel pins are asynchronous to clock.
//
// Behaviour
// RULE1: Capture copies counter into channel value
// RULE2: Capture edge rising, falling or either
// RULE3: Captured value read is byte coherent
// RULE4: Capture event sets channel event flag
// RULE5: Compare match sets, clears or toggles pin
// RULE6: Compare value loads after both halves
// RULE7: Compare match sets channel event flag
// RULE8: Edge PWM uses up counter and modulus
// RULE9: Edge PWM polarity set by low select
// RULE10: Zero gives 0%, above modulus 100%
// RULE11: Edge PWM value loads at count zero
// RULE12: Center PWM counts up then down
// RULE13: Software keeps center modulus nonzero, small
// RULE14: Center value zero or negative gives 0%
// RULE15: Center up match low, down match high
// RULE16: Center buffers load at counter reversal
// RULE17: Control writes discard pending half writes
// RULE18: Level request while flag and enable
// RULE19: Flag cleared by read then zero write
// RULE20: Up count overflow flag on wrap
// RULE21: Up/down overflow flag at reversal
// RULE22: Center select forces all channels center
// RULE23: Counter write zeroes counter and buffer
// RULE24: Center polarity one inverts output
// RULE25: Channel pins synchronised before edge detect
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module timer_channel_capture_compare_pwm
  import timer_channel_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // Clock, reset, freeze
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              clock_enable,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Channel pins
  input  wire logic [NUM_CH-1:0] ch_in,
  output logic      [NUM_CH-1:0] ch_out,
  output logic      [NUM_CH-1:0] ch_oe,
  // Interrupt requests
  output logic                   overflow_irq,
  output logic      [NUM_CH-1:0] channel_irq
);

  if (NUM_CH < 1 || NUM_CH > 8) begin : g_check
    $error("NUM_CH must be 1 to 8");
  end

  typedef struct packed {
    logic                   ack;
    logic                   err;
    logic [7:0]             rdata;
    logic [15:0]            count;
    logic                   down;
    logic                   en;
    logic                   cas;
    logic                   ovf;
    logic                   ovf_ie;
    logic                   ovf_arm;
    logic [15:0]            mod_act;
    logic [15:0]            mod_buf;
    logic                   mod_hw;
    logic                   mod_lw;
    logic                   cnt_lat;
    logic                   cnt_first_hi;
    logic [15:0]            cnt_buf;
    logic [NUM_CH-1:0][3:0] ch_ms_els;
    logic [NUM_CH-1:0]      ch_ie;
    logic [NUM_CH-1:0]      ch_flag;
    logic [NUM_CH-1:0]      ch_arm;
    logic [NUM_CH-1:0][15:0] ch_val;
    logic [NUM_CH-1:0][15:0] ch_buf;
    logic [NUM_CH-1:0]      ch_hw;
    logic [NUM_CH-1:0]      ch_lw;
    logic [NUM_CH-1:0]      ch_lat;
    logic [NUM_CH-1:0]      ch_first_hi;
    logic [NUM_CH-1:0][15:0] ch_rbuf;
    logic [NUM_CH-1:0]      ch_pin;
    logic [NUM_CH-1:0]      ch_drive;
    logic [NUM_CH-1:0]      pin_s1;
    logic [NUM_CH-1:0]      pin_s2;
    logic [NUM_CH-1:0]      pin_prev;
  } state_s;

  state_s st;
  state_s next_st;

  function automatic logic [7:0] ch_addr(input int n, input logic [7:0] off);
    ch_addr = 8'(int'(OFF_CH_BASE) + n * int'(OFF_CH_STRIDE) + int'(off));
  endfunction

  function automatic ch_mode_e ch_mode(input logic cas, input logic [3:0] ms_els);
    if (cas) begin
      ch_mode = MODE_CENTER;
    end else if (ms_els[3]) begin
      ch_mode = MODE_EDGE;
    end else if (ms_els[2]) begin
      ch_mode = MODE_COMPARE;
    end else begin
      ch_mode = MODE_CAPTURE;
    end
  endfunction

  logic       acc_first;
  logic       wr_fire;
  logic       rd_fire;
  logic       tick;
  logic [7:0] wb;

  assign acc_first = psel & penable & ~st.ack;
  assign wr_fire   = psel & penable & st.ack & pwrite;
  assign rd_fire   = acc_first & ~pwrite;
  assign tick      = st.en;
  assign wb        = pwdata[7:0];

  always_comb begin
    logic [15:0] term;
    logic        rev;
    logic        hit;
    logic        is_hi;
    logic [7:0]  rv;
    logic        rise;
    logic        fall;
    logic        cap_ev;
    logic        match;
    logic        active;
    ch_mode_e    md;
    term    = COUNT_MAX;
    rev     = 1'b0;
    hit     = 1'b0;
    is_hi   = 1'b0;
    rv      = 8'h00;
    rise    = 1'b0;
    fall    = 1'b0;
    cap_ev  = 1'b0;
    match   = 1'b0;
    active  = 1'b0;
    md      = MODE_CAPTURE;
    next_st = st;

    // APB answer one cycle into the access phase
    next_st.ack = acc_first;
    if (paddr == OFF_TIMER_CONTROL) begin
      hit = 1'b1;
      rv  = {st.ovf, st.ovf_ie, st.cas, 4'h0, st.en};
    end else if (paddr == OFF_COUNTER_HIGH || paddr == OFF_COUNTER_LOW) begin
      hit   = 1'b1;
      is_hi = (paddr == OFF_COUNTER_HIGH);
      rv    = st.cnt_lat ? (is_hi ? st.cnt_buf[15:8] : st.cnt_buf[7:0]) : (is_hi ? st.count[15:8] : st.count[7:0]);
    end else if (paddr == OFF_MODULUS_HIGH) begin
      hit = 1'b1;
      rv  = st.mod_act[15:8];
    end else if (paddr == OFF_MODULUS_LOW) begin
      hit = 1'b1;
      rv  = st.mod_act[7:0];
    end
    for (int n = 0; n < NUM_CH; n++) begin
      if (paddr == ch_addr(n, OFF_CH_CONTROL)) begin
        hit = 1'b1;
        rv  = {st.ch_flag[n], st.ch_ie[n], st.ch_ms_els[n], 2'b00};
      end else if (paddr == ch_addr(n, OFF_CH_VALUE_HIGH)) begin
        hit = 1'b1;
        rv  = st.ch_lat[n] ? st.ch_rbuf[n][15:8] : st.ch_val[n][15:8];
      end else if (paddr == ch_addr(n, OFF_CH_VALUE_LOW)) begin
        hit = 1'b1;
        rv  = st.ch_lat[n] ? st.ch_rbuf[n][7:0] : st.ch_val[n][7:0];
      end
    end
    if (acc_first) begin
      next_st.err   = ~hit;
      next_st.rdata = pwrite ? 8'h00 : rv;
    end

    // Counter advance
    term = (st.mod_act == COUNT_ZERO) ? COUNT_MAX : st.mod_act;
    if (tick) begin
      if (!st.cas) begin
        if (st.count == term) begin
          next_st.count = COUNT_ZERO; // RULE8 RULE20
        end else begin
          next_st.count = st.count + COUNT_ONE;
        end
      end else if (!st.down) begin
        if (st.count == st.mod_act && st.mod_act != COUNT_ZERO) begin
          rev           = 1'b1; // RULE12 RULE21
          next_st.down  = 1'b1;
          next_st.count = st.count - COUNT_ONE;
        end else begin
          next_st.count = st.count + COUNT_ONE;
        end
      end else if (st.count == COUNT_ZERO) begin
        next_st.down  = 1'b0; // RULE12
        next_st.count = st.count + COUNT_ONE;
      end else begin
        next_st.count = st.count - COUNT_ONE;
      end
    end

    // Counter read coherency
    if (rd_fire && (paddr == OFF_COUNTER_HIGH || paddr == OFF_COUNTER_LOW)) begin
      if (!st.cnt_lat) begin
        next_st.cnt_lat      = 1'b1;
        next_st.cnt_buf      = st.count;
        next_st.cnt_first_hi = is_hi;
      end else if (st.cnt_first_hi != is_hi) begin
        next_st.cnt_lat = 1'b0;
      end
    end
    if (rd_fire && paddr == OFF_TIMER_CONTROL && st.ovf) begin
      next_st.ovf_arm = 1'b1; // RULE19
    end

    // Timer register writes
    if (wr_fire) begin
      if (paddr == OFF_TIMER_CONTROL) begin
        next_st.ovf_ie  = wb[TC_IE];
        next_st.cas     = wb[TC_CAS]; // RULE22
        next_st.en      = wb[TC_EN];
        next_st.ovf_arm = 1'b0;
        next_st.mod_hw  = 1'b0; // RULE17
        next_st.mod_lw  = 1'b0;
        if (!wb[TC_FLAG] && st.ovf_arm) begin
          next_st.ovf = 1'b0; // RULE19
        end
      end else if (paddr == OFF_COUNTER_HIGH || paddr == OFF_COUNTER_LOW) begin
        next_st.count   = COUNT_ZERO; // RULE23
        next_st.down    = 1'b0;
        next_st.cnt_lat = 1'b0;
      end else if (paddr == OFF_MODULUS_HIGH) begin
        next_st.mod_buf[15:8] = wb;
        next_st.mod_hw        = 1'b1;
      end else if (paddr == OFF_MODULUS_LOW) begin
        next_st.mod_buf[7:0] = wb;
        next_st.mod_lw       = 1'b1;
      end
    end
    if (next_st.mod_hw && next_st.mod_lw && (!st.cas || rev)) begin
      next_st.mod_act = next_st.mod_buf; // RULE16
      next_st.mod_hw  = 1'b0;
      next_st.mod_lw  = 1'b0;
    end
    // Overflow event wins over a clear
    if (tick && ((!st.cas && st.count == term) || rev)) begin
      next_st.ovf     = 1'b1; // RULE20 RULE21 RULE19
      next_st.ovf_arm = 1'b0;
    end

    for (int n = 0; n < NUM_CH; n++) begin
      md = ch_mode(st.cas, st.ch_ms_els[n]); // RULE22
      next_st.pin_s1[n]   = ch_in[n]; // RULE25
      next_st.pin_s2[n]   = st.pin_s1[n];
      next_st.pin_prev[n] = st.pin_s2[n];
      rise   = st.pin_s2[n] & ~st.pin_prev[n];
      fall   = ~st.pin_s2[n] & st.pin_prev[n];
      cap_ev = (md == MODE_CAPTURE) && ((st.ch_ms_els[n][0] && rise) || (st.ch_ms_els[n][1] && fall)); // RULE2
      match  = tick && (st.count == st.ch_val[n]) && (md != MODE_CAPTURE);
      is_hi  = (paddr == ch_addr(n, OFF_CH_VALUE_HIGH));

      if (rd_fire && paddr == ch_addr(n, OFF_CH_CONTROL) && st.ch_flag[n]) begin
        next_st.ch_arm[n] = 1'b1; // RULE19
      end
      if (rd_fire && md == MODE_CAPTURE && (is_hi || paddr == ch_addr(n, OFF_CH_VALUE_LOW))) begin
        if (!st.ch_lat[n]) begin
          next_st.ch_lat[n]      = 1'b1; // RULE3
          next_st.ch_rbuf[n]     = st.ch_val[n];
          next_st.ch_first_hi[n] = is_hi;
        end else if (st.ch_first_hi[n] != is_hi) begin
          next_st.ch_lat[n] = 1'b0; // RULE3
        end
      end

      if (wr_fire && paddr == ch_addr(n, OFF_CH_CONTROL)) begin
        next_st.ch_ie[n]     = wb[CC_IE];
        next_st.ch_ms_els[n] = wb[CC_MSB:CC_ELSA];
        next_st.ch_arm[n]    = 1'b0;
        next_st.ch_hw[n]     = 1'b0; // RULE6 RULE17
        next_st.ch_lw[n]     = 1'b0;
        next_st.ch_lat[n]    = 1'b0; // RULE3
        if (!wb[CC_FLAG] && st.ch_arm[n]) begin
          next_st.ch_flag[n] = 1'b0; // RULE19
        end
      end else if (wr_fire && is_hi) begin
        next_st.ch_buf[n][15:8] = wb;
        next_st.ch_hw[n]        = 1'b1;
      end else if (wr_fire && paddr == ch_addr(n, OFF_CH_VALUE_LOW)) begin
        next_st.ch_buf[n][7:0] = wb;
        next_st.ch_lw[n]       = 1'b1;
      end

      // Buffered value transfer per mode
      if (next_st.ch_hw[n] && next_st.ch_lw[n]) begin
        if ((md == MODE_COMPARE || md == MODE_CAPTURE)                  // RULE6
            || (md == MODE_EDGE && st.count == COUNT_ZERO)              // RULE11
            || (md == MODE_CENTER && rev)) begin                        // RULE16
          next_st.ch_val[n] = next_st.ch_buf[n];
          next_st.ch_hw[n]  = 1'b0;
          next_st.ch_lw[n]  = 1'b0;
        end
      end
      if (cap_ev) begin
        next_st.ch_val[n] = st.count; // RULE1
      end
      if (cap_ev || match) begin
        next_st.ch_flag[n] = 1'b1; // RULE4 RULE7 RULE19
        next_st.ch_arm[n]  = 1'b0;
      end

      // Pin behaviour
      next_st.ch_drive[n] = (md != MODE_CAPTURE) && (next_st.ch_ms_els[n][1:0] != 2'b00);
      if (md == MODE_COMPARE && match) begin
        case (st.ch_ms_els[n][1:0])
          2'b01:   next_st.ch_pin[n] = ~st.ch_pin[n]; // RULE5
          2'b10:   next_st.ch_pin[n] = 1'b0;
          2'b11:   next_st.ch_pin[n] = 1'b1;
          default: next_st.ch_pin[n] = st.ch_pin[n];
        endcase
      end else if (md == MODE_EDGE) begin
        active             = next_st.count < next_st.ch_val[n]; // RULE10
        next_st.ch_pin[n] = active ^ st.ch_ms_els[n][0]; // RULE9
      end else if (md == MODE_CENTER) begin
        active = (next_st.ch_val[n] != COUNT_ZERO) && !next_st.ch_val[n][SIGN_BIT] // RULE14
                 && ((next_st.count < next_st.ch_val[n])
                     || (next_st.count == next_st.ch_val[n] && next_st.down));
        next_st.ch_pin[n] = active ^ st.ch_ms_els[n][0]; // RULE15 RULE24
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else if (clock_enable) begin
      st <= next_st;
    end
  end

  assign pready       = psel & penable & st.ack;
  assign pslverr      = pready & st.err;
  assign prdata       = {24'h00_0000, st.rdata};
  assign ch_out       = st.ch_pin;
  assign ch_oe        = st.ch_drive;
  assign overflow_irq = st.ovf & st.ovf_ie; // RULE18
  assign channel_irq  = st.ch_flag & st.ch_ie; // RULE18

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  cap_copy_a: assert property (clock_enable && st.ch_ms_els[0] == 4'b0011 && !st.cas && st.pin_s2[0] != st.pin_prev[0] // RULE1
                               |=> st.ch_val[0] == $past(st.count) && st.ch_flag[0])
    else $error("capture did not copy counter");
  rise_only_a: assert property (clock_enable && st.ch_ms_els[0] == 4'b0001 && !st.cas && !st.ch_flag[0] // RULE2
                                && !st.pin_s2[0] && st.pin_prev[0] && !wr_fire |=> !st.ch_flag[0])
    else $error("falling edge captured in rising mode");
  up_wrap_a: assert property (clock_enable && tick && !st.cas && !wr_fire // RULE20
                              && st.count == ((st.mod_act == COUNT_ZERO) ? COUNT_MAX : st.mod_act)
                              |=> st.count == COUNT_ZERO && st.ovf)
    else $error("up counter did not wrap with overflow flag");
  reverse_ovf_a: assert property (clock_enable && tick && st.cas && !st.down && !wr_fire // RULE21
                                  && st.count == st.mod_act && st.mod_act != COUNT_ZERO
                                  |=> st.down && st.ovf && st.count == $past(st.mod_act) - COUNT_ONE)
    else $error("center counter did not reverse with overflow flag");
  edge_level_a: assert property (clock_enable && !st.cas && st.ch_ms_els[NUM_CH-1][3] && !wr_fire // RULE9
                                 |=> st.ch_pin[NUM_CH-1]
                                     == ((st.count < st.ch_val[NUM_CH-1]) ^ st.ch_ms_els[NUM_CH-1][0]))
    else $error("edge pwm output level wrong");
  center_zero_a: assert property (clock_enable && st.cas && !wr_fire && st.ch_val[NUM_CH-1][SIGN_BIT] // RULE14
                                  && !st.ch_hw[NUM_CH-1] ##1 clock_enable
                                  |=> st.ch_pin[NUM_CH-1] == $past(st.ch_ms_els[NUM_CH-1][0], 2))
    else $error("negative center value not 0 percent");
  flag_hold_a: assert property (clock_enable && st.ch_flag[0] && (rd_fire || wr_fire) // RULE19
                                && st.ch_ms_els[0][2] && !st.cas && tick && st.count == st.ch_val[0]
                                |=> st.ch_flag[0])
    else $error("channel flag lost on simultaneous event");
  irq_level_a: assert property (st.ovf && st.ovf_ie |-> overflow_irq ##1 (overflow_irq == (st.ovf && st.ovf_ie))) // RULE18
    else $error("overflow request not level");
  cnt_reset_a: assert property (clock_enable && wr_fire && paddr == OFF_COUNTER_LOW // RULE23
                                |=> st.count == COUNT_ZERO && !st.cnt_lat)
    else $error("counter write did not reset");
  ctl_cancel_a: assert property (clock_enable && wr_fire && paddr == ch_addr(0, OFF_CH_CONTROL) // RULE17
                                 |=> !st.ch_hw[0] && !st.ch_lw[0] && !st.ch_lat[0])
    else $error("control write did not cancel value sequence");

endmodule

`default_nettype wire

// File: bench/pin_model.sv
// Pin-side partner: drives channel input pins, measures driven outputs.
// Assumes it shares the timer block clock; counts clear on clr.
`timescale 1ns/100ps
`default_nettype none

module pin_model #(
  parameter int N = 2
) (
  // Clock and bench control
  input  wire logic         clock,
  input  wire logic         clr,
  input  wire logic [N-1:0] lvl,
  // Channel pins
  output logic      [N-1:0] ch_in,
  input  wire logic [N-1:0] ch_out,
  input  wire logic [N-1:0] ch_oe,
  // Measurements
  output int                hi [N],
  output int                tg [N]
);
  logic [N-1:0] last;

  // Pin levels launched on the clock grid the block samples on
  always @(posedge clock) begin
    ch_in <= lvl;
    last  <= ch_out;
    for (int i = 0; i < N; i++) begin
      hi[i] <= clr ? 0 : hi[i] + int'(ch_out[i] & ch_oe[i]);
      tg[i] <= clr ? 0 : tg[i] + int'(ch_out[i] != last[i]);
    end
  end
endmodule

`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the timer channel block, registers over APB.
// Assumes the package, the block and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import timer_channel_pkg::*;
;
  logic        clock;
  logic        srst;
  logic        clock_enable;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  ch_in;
  logic [1:0]  ch_out;
  logic [1:0]  ch_oe;
  logic        overflow_irq;
  logic [1:0]  channel_irq;
  logic [1:0]  lvl;
  logic        clr;
  logic [7:0]  rd;
  logic        er;
  logic        hit;
  logic [15:0] cap;
  logic [15:0] val [6];
  int          hi [2];
  int          tg [2];
  int          fail_count;
  int          num_checks;
  int          seed;

  timer_channel_capture_compare_pwm #(.NUM_CH(2)) timer_channel_capture_compare_pwm_inst (
    .clock(clock), .srst(srst), .clock_enable(clock_enable), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq));

  pin_model #(.N(2)) pin_model_inst (
    .clock(clock), .clr(clr), .lvl(lvl), .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe),
    .hi(hi), .tg(tg));

  // Reference duty models, high cycles per period
  function automatic int epwm(int v, int m, int pol);
    int d;
    d = (v > m) ? m + 1 : v;
    return pol ? m + 1 - d : d;
  endfunction

  function automatic int cduty(int v, int m, int pol);
    int d;
    // The top count is visited once, on the up slope
    d = (v == 0 || v > 32767) ? 0 : (v > m) ? 2 * m : (v == m) ? 2 * m - 1 : 2 * v;
    return pol ? 2 * m - d : d;
  endfunction

  function automatic logic [7:0] ca(int n, logic [7:0] off);
    return 8'(int'(OFF_CH_BASE) + int'(OFF_CH_STRIDE) * n + int'(off));
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask

  // Loads channel 1, lets it settle, counts high cycles over n clocks
  task automatic pwm(input logic [7:0] c, input logic [15:0] v, input int exp, input int n);
    wr(ca(1, OFF_CH_CONTROL), c);
    wr(ca(1, OFF_CH_VALUE_HIGH), v[15:8]);
    wr(ca(1, OFF_CH_VALUE_LOW), v[7:0]);
    meas(n);
    chk(hi[1], exp);
  endtask

  task automatic meas(input int n);
    repeat (50) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #(20 * 20000);
    fail_count++;
    print_verdict();
  end

  initial begin
    {srst, clr, clock_enable} = 3'b111;
    {psel, penable, pwrite, paddr, pwdata, lvl} = '0;
    seed = 32'he6a6;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    clr  <= 1'b0;
    rchk(OFF_TIMER_CONTROL, 8'h00);
    rchk(ca(0, OFF_CH_CONTROL), 8'h00);
    chk({ch_out, ch_oe, overflow_irq, channel_irq}, 32'h0000_0000);
    apb(1'b0, 8'hFC, 8'h00);
    chk({er, rd}, 32'h0000_0100);
    // Run, stop, then read a frozen count for capture
    wr(OFF_TIMER_CONTROL, 8'h01);
    repeat (37) @(posedge clock);
    wr(OFF_TIMER_CONTROL, 8'h00);
    apb(1'b0, OFF_COUNTER_HIGH, 8'h00);
    cap[15:8] = rd;
    apb(1'b0, OFF_COUNTER_LOW, 8'h00);
    cap[7:0] = rd;
    for (int s = 1; s < 4; s++) begin
      wr(ca(0, OFF_CH_CONTROL), 8'(8'h40 | (s << 2)));
      apb(1'b0, ca(0, OFF_CH_CONTROL), 8'h00);
      wr(ca(0, OFF_CH_CONTROL), 8'(8'h40 | (s << 2)));
      for (int e = 1; e >= 0; e--) begin
        hit = e ? s[0] : s[1];
        lvl[0] <= e[0];
        repeat (8) @(posedge clock);
        #1;
        chk(channel_irq[0], hit);
        apb(1'b0, ca(0, OFF_CH_CONTROL), 8'h00);
        chk(rd[7], hit);
        wr(ca(0, OFF_CH_CONTROL), 8'(8'h40 | (s << 2)));
        rchk(ca(0, OFF_CH_CONTROL), 8'(8'h40 | (s << 2)));
        rchk(ca(0, OFF_CH_VALUE_HIGH), cap[15:8]);
        rchk(ca(0, OFF_CH_VALUE_LOW), cap[7:0]);
      end
    end
    // Latched capture survives a new capture until the other byte is read
    rchk(ca(0, OFF_CH_VALUE_HIGH), cap[15:8]);
    wr(OFF_COUNTER_HIGH, 8'h5A);
    rchk(OFF_COUNTER_LOW, 8'h00);
    rchk(OFF_COUNTER_HIGH, 8'h00);
    lvl[0] <= 1'b1;
    repeat (8) @(posedge clock);
    rchk(ca(0, OFF_CH_VALUE_LOW), cap[7:0]);
    rchk(ca(0, OFF_CH_VALUE_HIGH), 8'h00);
    rchk(ca(0, OFF_CH_VALUE_LOW), 8'h00);
    // Edge-aligned PWM, modulus 9
    wr(OFF_TIMER_CONTROL, 8'h01);
    wr(OFF_MODULUS_HIGH, 8'h00);
    wr(OFF_MODULUS_LOW, 8'h09);
    val = '{16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h000A, 16'h0000};
    val[5] = 16'(1 + $unsigned($random(seed)) % 9);
    for (int k = 0; k < 6; k++) begin
      pwm(8'(8'h28 | (k[0] << 2)), val[k], 4 * epwm(val[k], 9, k[0]), 40);
    end
    apb(1'b0, OFF_TIMER_CONTROL, 8'h00);
    chk(rd[7], 1'b1);
    wr(OFF_TIMER_CONTROL, 8'h41);
    repeat (12) @(posedge clock);
    #1;
    chk(overflow_irq, 1'b1);
    // Center-aligned PWM, modulus 8, channel mode bits left at capture
    wr(OFF_TIMER_CONTROL, 8'h21);
    wr(OFF_MODULUS_LOW, 8'h08);
    wr(OFF_MODULUS_HIGH, 8'h00);
    val = '{16'h0000, 16'h0003, 16'h0003, 16'h8000, 16'h0009, 16'h0000};
    val[5] = 16'(1 + $unsigned($random(seed)) % 8);
    for (int k = 0; k < 6; k++) begin
      pwm(8'(8'h08 | (k[0] << 2)), val[k], 4 * cduty(val[k], 8, k[0]), 64);
    end
    apb(1'b0, OFF_TIMER_CONTROL, 8'h00);
    chk(rd[7], 1'b1);
    // Output compare on channel 0: toggle, clear, set
    wr(OFF_TIMER_CONTROL, 8'h01);
    wr(OFF_MODULUS_LOW, 8'h09);
    wr(OFF_MODULUS_HIGH, 8'h00);
    for (int j = 1; j < 4; j++) begin
      wr(ca(0, OFF_CH_CONTROL), 8'(8'h10 | (j << 2)));
      wr(ca(0, OFF_CH_VALUE_LOW), 8'h05);
      wr(ca(0, OFF_CH_VALUE_HIGH), 8'h00);
      meas(40);
      chk((j == 1) ? tg[0] : hi[0], (j == 1) ? 4 : (j == 2) ? 0 : 40);
    end
    apb(1'b0, ca(0, OFF_CH_CONTROL), 8'h00);
    chk(rd[7], 1'b1);
    // Low clock enable holds the counter: only setup and access edges tick
    wr(OFF_TIMER_CONTROL, 8'h00);
    wr(OFF_COUNTER_LOW, 8'h00);
    wr(OFF_TIMER_CONTROL, 8'h01);
    clock_enable <= 1'b0;
    repeat (5) @(posedge clock);
    clock_enable <= 1'b1;
    rchk(OFF_COUNTER_LOW, 8'h02);
    print_verdict();
  end
endmodule

`default_nettype wire
